/* tb_eight_bit_prescaled_timer.sv */
/* Bench for the prescaled timer: AHB-Lite master, pin source, checks.
   Assumes timer_top, timer_pin_src and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_eight_bit_prescaled_timer;
    logic        clk = 0, nrst = 0, hsel = 0, hwrite = 0, rd_dp = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, d, q[$];
    logic [1:0]  htrans = 0;
    logic [3:0]  npulse = 0;
    logic        hresp, pin_out, pin_oe, irq, pin, busy, go = 0, lvl = 0;
    wire         hready;
    int          mismatches = 0, n_tests = 0, seed = 32'h2bae, i, n;
    timer_top u_dut (.CLK_SYS(clk), .NRST(nrst), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
        .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .TIMER_PIN_IN(pin),
        .TIMER_PIN_OUT(pin_out), .TIMER_PIN_OE(pin_oe), .IRQ(irq));
    timer_pin_src u_src (.clk(clk), .oe(pin_oe), .dout(pin_out),
        .lvl(lvl), .go(go), .npulse(npulse), .pin(pin), .busy(busy));
    initial forever #2.5 clk = ~clk;
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Reads note their expectation; the watcher below compares
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        if (!w)
            q.push_back(v);
        do @(posedge clk); while (!hready);
        htrans <= 2'b00;
        hwdata <= v;
        rd_dp <= !w;
        do @(posedge clk); while (!hready);
        rd_dp <= 1'b0;
    endtask
    always @(posedge clk)
        if (rd_dp && hready)
            chk(hrdata, q.pop_front());
    task wait_irq(input int lim);
        for (n = 0; irq !== 1'b1 && n < lim; n++) @(posedge clk);
    endtask
    task pulses(input logic [3:0] k);
        go <= 1'b1;
        npulse <= k;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (n = 0; busy && n < 300; n++) @(posedge clk);
        repeat (8) @(posedge clk);
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        xfer(0, 8'h00, 32'h00);
        xfer(0, 8'h20, 32'h00);
        xfer(1, 8'h00, 32'h09);
        for (i = 0; i < 4; i++) begin
            d = $random(seed) & 32'h7F;
            xfer(1, 8'h08, d);
            xfer(0, 8'h08, d);
        end
        $display("test registers done");
        xfer(1, 8'h08, 32'h7F);
        xfer(1, 8'h04, 32'h02);
        xfer(1, 8'h00, 32'h49);
        pulses(3);
        chk(irq, 0);
        pulses(1);
        chk(irq, 1);
        $display("test event done");
        xfer(1, 8'h00, 32'h08);
        xfer(1, 8'h04, 32'h02);
        xfer(1, 8'h00, 32'h58);
        repeat (100) @(posedge clk);
        chk(irq, 0);
        lvl <= 1'b1;
        wait_irq(60);
        chk(irq, 1);
        lvl <= 1'b0;
        $display("test gated done");
        // Flag set by software with data low: latch starts at zero
        xfer(1, 8'h00, 32'h88);
        repeat (3) @(posedge clk);
        chk(pin_out, 0);
        xfer(1, 8'h04, 32'h03);
        xfer(1, 8'h00, 32'h78);
        wait_irq(60);
        chk(n >= 24 && n <= 40, 1);
        // Pin follows the latch two edges after the flag
        repeat (2) @(posedge clk);
        chk({pin_oe, pin_out}, 3);
        xfer(1, 8'h00, 32'h68);
        repeat (3) @(posedge clk);
        chk({irq, pin_out}, 1);
        xfer(1, 8'h10, 32'h01);
        repeat (3) @(posedge clk);
        chk(irq, 1);
        xfer(1, 8'h14, 32'h03);
        repeat (3) @(posedge clk);
        chk(irq, 0);
        $display("test output done");
        // Factor 8: bit 2 rises on the eighth edge after 7Fh.
        // Count loaded after the prescaler, so a reload tap edge is lost.
        xfer(1, 8'h00, 32'h4B);
        xfer(1, 8'h08, 32'h7F);
        xfer(1, 8'h04, 32'h01);
        pulses(7);
        chk(irq, 0);
        pulses(1);
        chk(irq, 1);
        $display("test tap done");
        // Reset mid-run, counting in event mode with the pin not driven
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        xfer(0, 8'h00, 32'h00);
        repeat (60) @(posedge clk);
        xfer(0, 8'h04, 32'hFF);
        xfer(0, 8'h08, 32'h7F);
        $display("test reset done");
        @(posedge clk);
        results;
    end
    // Tests need under 600 cycles; the 20000-cycle limit means a hang
    initial begin
        #100000;
        mismatches++;
        results;
    end
endmodule // tb_eight_bit_prescaled_timer
`default_nettype wire

/* timer_clkdiv.v */
/*
 Divide-by-12 enable generator for the timer prescaler.
 Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.vh"

module timer_clkdiv (
    input  wire       clk,
    input  wire       rst_n,
    output reg        tick
);
    reg [3:0] cnt_q;

    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            tick  <= 1'b0;
        end else if (cnt_q == `DIV_LAST) begin
            cnt_q <= 4'h0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            tick  <= 1'b0;
        end
    end
endmodule // timer_clkdiv

`default_nettype wire

/* timer_defs.vh */
/*
 Constants for the 8-bit prescaled timer: AHB register byte addresses,
 control byte fields, reset values and clock divider figures.
 Assumes inclusion by bare name from the timer design files.
*/
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// Register byte addresses (word aligned, index times four)
`define ADDR_CTRL      8'h00
`define ADDR_COUNT     8'h04
`define ADDR_PRESC     8'h08
`define ADDR_IRQ_STAT  8'h0C
`define ADDR_IRQ_EN    8'h10
`define ADDR_IRQ_CLR   8'h14
`define ADDR_PIN       8'h18

// Control byte field positions
`define CTL_ZERO       7
`define CTL_IRQEN      6
`define CTL_DIR        5
`define CTL_DOUT       4
`define CTL_RUN        3
`define CTL_TAP_HI     2

// Reset values and the prescaler all-ones hold value
`define COUNT_RST      8'hFF
`define PRESC_RST      7'h7F
`define CTRL_RST       8'h00
`define PRESC_MAX      7'h7F

// Internal clock divide before the prescaler
`define DIV_FACTOR     12
`define DIV_LAST       4'hB

// Interrupt status bits
`define IRQ_ZERO       0
`define IRQ_PINEDGE    1

`endif

/* timer_pin_src.sv */
/* Timing pin source: pulse trains or a held level on the shared pin.
   Assumes the bench clock; the timer's drive wins while its enable is up. */
`timescale 1ns/1ps
`default_nettype none
module timer_pin_src (
    input  wire logic       clk,
    input  wire logic       oe,
    input  wire logic       dout,
    input  wire logic       lvl,
    input  wire logic       go,
    input  wire logic [3:0] npulse,
    output var  logic       pin,
    output var  logic       busy
);
    logic [3:0] n_q = 4'h0;
    logic [3:0] ph_q = 4'h0;
    // Low half first, so every pulse gives one clean rising edge
    always @(posedge clk) begin
        if (go) begin
            n_q <= npulse;
            ph_q <= 4'h0;
        end else if (n_q != 4'h0) begin
            ph_q <= ph_q + 4'h1;
            if (ph_q == 4'hF)
                n_q <= n_q - 4'h1;
        end
    end
    assign busy = (n_q != 4'h0);
    assign pin = oe ? dout : (busy ? ph_q[3] : lvl);
endmodule // timer_pin_src
`default_nettype wire

/* timer_top.v */
/*
 8-bit down-counter with 7-bit prescaler, AHB-Lite register slave,
 gated / event / output modes on the timing pin, and interrupt logic.
 Assumes a single AHB-Lite master, single word transfers, one clock.
*/
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.vh"

// How it works
// - Counter decrements on each selected tap edge
// - Reaching zero sets the zero flag
// - Zero flag with enable raises interrupt
// - Interrupt level usable to wake processor
// - Prescaler input: clock/12 or timing pin
// - Prescaler decrements on each input edge
// - Counter clock taken from chosen prescaler tap
// - Run bit low forces prescaler ones, stops
// - Software loads prescaler 0..7Fh while running
// - Count writable/readable, prescaler readable
// - Gated mode counts clock/12 while pin high
// - Event mode counts timing pin rising edges
// - Output mode drives pin from data latch
// - Latch follows data bit while zero flag high
// - Tap select 0..7 divides by 1..128
// - Reset: count FFh, prescaler 7Fh, control zero
// - Count write beats simultaneous decrement to zero
module timer_top (
    input  wire        CLK_SYS,
    input  wire        NRST,
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output reg  [31:0] HRDATA,
    output reg         HREADYOUT,
    output reg         HRESP,
    input  wire        TIMER_PIN_IN,
    output reg         TIMER_PIN_OUT,
    output reg         TIMER_PIN_OE,
    output reg         IRQ
);
    // Bus address phase capture
    reg        wr_q;
    reg        rd_q;
    reg [7:0]  addr_q;

    // Timer state
    reg [7:0]  count_q;
    reg [6:0]  presc_q;
    reg [7:0]  ctrl_q;
    reg        pin_latch_q;
    reg        zero_prev_q;
    reg        tap_prev_q;
    reg        pin_s1_q;
    reg        pin_s2_q;
    reg        pin_prev_q;
    reg [1:0]  stat_q;
    reg [1:0]  en_q;

    wire       tick12;
    wire       run      = ctrl_q[`CTL_RUN];
    wire       dir_out  = ctrl_q[`CTL_DIR];
    wire       dout     = ctrl_q[`CTL_DOUT];
    wire [2:0] tap_sel  = ctrl_q[`CTL_TAP_HI:0];
    wire       pin_rise = pin_s2_q & ~pin_prev_q;

    timer_clkdiv u_div (
        .clk   (CLK_SYS),
        .rst_n (NRST),
        .tick  (tick12)
    );

    // Prescaler input enable by mode
    reg presc_en;
    always @* begin
        if (dir_out)
            presc_en = tick12;
        else if (dout)
            presc_en = tick12 & pin_s2_q;
        else
            presc_en = pin_rise;
    end

    // Next prescaler value; bit 0 toggles each input edge
    wire [6:0] presc_nx = presc_q - 7'h01;

    // Tap level before/after: a tap edge is a rising tap bit.
    // Factor 1 uses the prescaler input itself.
    function tap_bit;
        input [2:0] sel;
        input [6:0] p;
        begin
            tap_bit = p[sel - 3'd1];
        end
    endfunction

    wire tap_now = tap_bit(tap_sel, presc_q);
    wire cnt_en  = run && ((tap_sel == 3'd0) ? presc_en
                   : (tap_now & ~tap_prev_q));

    // Bus side write decode
    wire wr_ctrl  = wr_q && (addr_q == `ADDR_CTRL);
    wire wr_count = wr_q && (addr_q == `ADDR_COUNT);
    wire wr_presc = wr_q && (addr_q == `ADDR_PRESC);
    wire wr_en    = wr_q && (addr_q == `ADDR_IRQ_EN);
    wire wr_clr   = wr_q && (addr_q == `ADDR_IRQ_CLR);

    wire hits_zero = cnt_en && (count_q == 8'h01) && !wr_count;
    wire zero_now  = ctrl_q[`CTL_ZERO];

    // AHB-Lite slave, zero wait states
    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            addr_q    <= 8'h00;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            HRDATA    <= 32'h0000_0000;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            if (HREADY) begin
                wr_q   <= HSEL & HTRANS[1] & HWRITE;
                rd_q   <= HSEL & HTRANS[1] & ~HWRITE;
                addr_q <= HADDR[7:0];
                // Read data registered at the address edge
                if (HSEL & HTRANS[1] & ~HWRITE) begin
                    case (HADDR[7:0])
                        `ADDR_CTRL:     HRDATA <= {24'h00_0000, ctrl_q};
                        `ADDR_COUNT:    HRDATA <= {24'h00_0000, count_q};
                        `ADDR_PRESC:    HRDATA <= {25'h000_0000, presc_q};
                        `ADDR_IRQ_STAT: HRDATA <= {30'h0000_0000, stat_q};
                        `ADDR_IRQ_EN:   HRDATA <= {30'h0000_0000, en_q};
                        `ADDR_PIN:      HRDATA <= {31'h0000_0000, pin_s2_q};
                        default:        HRDATA <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // Timer core
    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            count_q     <= `COUNT_RST;
            presc_q     <= `PRESC_RST;
            ctrl_q      <= `CTRL_RST;
            tap_prev_q  <= 1'b1;
            zero_prev_q <= 1'b0;
            pin_latch_q <= 1'b0;
        end else begin
            // Run low holds prescaler at all ones
            if (!run)
                presc_q <= `PRESC_MAX;
            else if (wr_presc)
                presc_q <= HWDATA[6:0];
            else if (presc_en)
                presc_q <= presc_nx;
            tap_prev_q <= run ? tap_now : 1'b1;

            if (wr_count)
                count_q <= HWDATA[7:0];
            else if (cnt_en)
                count_q <= count_q - 8'h01;

            if (wr_ctrl)
                ctrl_q <= HWDATA[7:0];
            // Hardware set wins over software clear
            if (hits_zero || (wr_count && HWDATA[7:0] == 8'h00))
                ctrl_q[`CTL_ZERO] <= 1'b1;

            zero_prev_q <= zero_now;
            // Latch transparent while flag high
            if (zero_now && !zero_prev_q)
                pin_latch_q <= dout;
            else if (zero_now)
                pin_latch_q <= dout;
        end
    end

    // Sticky status, enable, write-one-to-clear
    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            stat_q <= 2'b00;
            en_q   <= 2'b00;
        end else begin
            if (wr_en)
                en_q <= HWDATA[1:0];
            stat_q[`IRQ_ZERO] <= hits_zero |
                (stat_q[`IRQ_ZERO] & ~(wr_clr & HWDATA[`IRQ_ZERO]));
            stat_q[`IRQ_PINEDGE] <= pin_rise |
                (stat_q[`IRQ_PINEDGE] & ~(wr_clr & HWDATA[`IRQ_PINEDGE]));
        end
    end

    // Pin synchroniser and outputs
    always @(posedge CLK_SYS) begin
        if (!NRST) begin
            pin_s1_q      <= 1'b0;
            pin_s2_q      <= 1'b0;
            pin_prev_q    <= 1'b0;
            TIMER_PIN_OUT <= 1'b0;
            TIMER_PIN_OE  <= 1'b0;
            IRQ           <= 1'b0;
        end else begin
            pin_s1_q      <= TIMER_PIN_IN;
            pin_s2_q      <= pin_s1_q;
            pin_prev_q    <= pin_s2_q;
            TIMER_PIN_OUT <= pin_latch_q;
            TIMER_PIN_OE  <= dir_out;
            // Level output, also the wake request
            IRQ <= (zero_now & ctrl_q[`CTL_IRQEN]) |
                   |(stat_q & en_q);
        end
    end
endmodule // timer_top

`default_nettype wire

/* timer_top_chk.sv */
/* Port checker for the prescaled timer.
   Assumes bind onto timer_top, one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module timer_chk (
    input wire logic        CLK_SYS,
    input wire logic        NRST,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        TIMER_PIN_OE,
    input wire logic        IRQ
);
    wire logic tk = HSEL && HTRANS[1] && HREADY;
    wire logic rd = tk && !HWRITE;
    wire logic wr = tk && HWRITE;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    resp_okay_a: assert property (!HRESP && HREADYOUT)
        else $error("bad response or wait state");
    reset_quiet_a: assert property (disable iff (1'b0)
        !NRST |=> !IRQ && !TIMER_PIN_OE && HRDATA == 32'h0)
        else $error("outputs not cleared by reset");
    rdata_hold_a: assert property (!rd |=> $stable(HRDATA))
        else $error("read data moved without a read");
    presc_bits_a: assert property (rd && HADDR[7:0] == 8'h08
        |=> HRDATA[31:7] == 25'h0) else $error("prescaler top bits set");
    pin_bits_a: assert property (rd && HADDR[7:0] == 8'h18
        |=> HRDATA[31:1] == 31'h0) else $error("pin level too wide");
    unmapped_zero_a: assert property (rd && HADDR[7:0] > 8'h18
        |=> HRDATA == 32'h0) else $error("unmapped read not zero");
    oe_cause_a: assert property ($changed(TIMER_PIN_OE)
        |-> $past(wr, 2) || $past(wr, 3)) else $error("pin mode moved");
    irq_clear_a: assert property ($fell(IRQ)
        |-> $past(wr, 2) || $past(wr, 3)) else $error("irq dropped");
endmodule // timer_chk
bind timer_top timer_chk u_chk (.CLK_SYS, .NRST, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .TIMER_PIN_OE, .IRQ);
`default_nettype wire
